/* src/fast_serial_map.svh */
// constants for the opto-isolated fast serial link
`ifndef FAST_SERIAL_MAP_SVH
`define FAST_SERIAL_MAP_SVH
`define FS_FRAME_BITS 4'ha
`define FS_DATA_BITS 4'h8
`define FS_CHAN_FIRST 1'b0
`define FS_CHAN_SECOND 1'b1
`define FS_START_LEVEL 1'b0
`define FS_HOLD_CMD 2'h2
`define FS_RELEASE_CMD 2'h0
`define FS_CLK_DIV 4'h4
`endif

/* src/fast_serial_pkg.sv */
// types used by the device end of the fast serial link
package fast_serial_pkg;
    typedef enum logic [1:0] {LINK_IDLE, LINK_RX, LINK_TX} link_state_type;
endpackage

/* src/fast_serial_if.sv */
// wires of the four-wire fast serial link
`timescale 1ns/1ps
interface fast_serial_if;
    logic linkClock;
    logic serialInLine;
    logic serialOutLine;
    logic clearToSendOut;
    modport device (input linkClock, input serialInLine, output serialOutLine,
        output clearToSendOut);
    modport host (output linkClock, output serialInLine, input serialOutLine,
        input clearToSendOut);
endinterface

/* src/fast_serial_device.sv */
// device end of the fast serial link; link side clocked by the link clock, user side by clk
`timescale 1ns/1ps
`include "fast_serial_map.svh"
module fast_serial_device (
    input wire logic clk,
    input wire logic reset,
    fast_serial_if.device link,
    input wire logic chanEnA,
    input wire logic chanEnB,
    input wire logic [1:0] modeCmd,
    input wire logic modeCmdValid,
    input wire logic [7:0] txByte,
    input wire logic txChan,
    input wire logic txValid,
    output logic txReady,
    output logic [7:0] rxByte,
    output logic rxChan,
    output logic rxValid,
    input wire logic rxReady
);
    // ----------------------------------------------------------------
    // user side, clk domain
    // ----------------------------------------------------------------
    logic holdReset_q;
    logic [7:0] txByte_q;
    logic txChan_q;
    logic txFull_q;
    logic txReq_q;
    logic [1:0] txAckSync_q;
    logic txAckSeen_q;
    logic [1:0] rxTglSync_q;
    logic rxTglSeen_q;
    logic rxAck_q;
    logic [1:0] enSync_q;
    // link side signals
    logic txAck_q;
    logic rxTgl_q;
    logic [7:0] rxShift_q;
    logic rxChanL_q;
    logic [1:0] txReqSync_q;
    logic [1:0] rxAckSync_q;
    logic rxAckSeen_q;
    logic rxPending_q;
    logic [1:0] linkEnSync_q;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            holdReset_q <= 1'b0;
        end else if (modeCmdValid && modeCmd == `FS_HOLD_CMD) begin
            holdReset_q <= 1'b1;
        end else if (modeCmdValid && modeCmd == `FS_RELEASE_CMD) begin
            holdReset_q <= 1'b0;
        end
    end

    // one-byte holding stage; takes one byte while held reset and sends it on release
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            txByte_q <= 8'h00;
            txChan_q <= 1'b0;
            txFull_q <= 1'b0;
            txReq_q <= 1'b0;
            txAckSync_q <= 2'h0;
            txAckSeen_q <= 1'b0;
        end else begin
            txAckSync_q <= {txAckSync_q[0], txAck_q};
            txAckSeen_q <= txAckSync_q[1];
            if (txAckSync_q[1] != txAckSeen_q) begin
                txFull_q <= 1'b0;
            end else if (txValid && txReady) begin
                txByte_q <= txByte;
                txChan_q <= txChan;
                txFull_q <= 1'b1;
            end
            if (txFull_q && !holdReset_q && txReq_q == txAckSeen_q
                && txAckSync_q[1] == txAckSeen_q) begin
                txReq_q <= ~txReq_q;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            txReady <= 1'b0;
        end else begin
            txReady <= !txFull_q && !(txValid && txReady);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rxTglSync_q <= 2'h0;
            rxTglSeen_q <= 1'b0;
            rxByte <= 8'h00;
            rxChan <= 1'b0;
            rxValid <= 1'b0;
            rxAck_q <= 1'b0;
        end else begin
            rxTglSync_q <= {rxTglSync_q[0], rxTgl_q};
            if (rxValid && rxReady) begin
                rxValid <= 1'b0;
                rxAck_q <= ~rxAck_q;
            end else if (rxTglSync_q[1] != rxTglSeen_q) begin
                rxTglSeen_q <= rxTglSync_q[1];
                rxByte <= rxShift_q;
                rxChan <= rxChanL_q;
                rxValid <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            enSync_q <= 2'h0;
        end else begin
            enSync_q <= {enSync_q[0], (chanEnA || chanEnB) && !holdReset_q};
        end
    end

    // ----------------------------------------------------------------
    // link side, link clock domain
    // ----------------------------------------------------------------
    fast_serial_pkg::link_state_type state_q;
    logic [3:0] bitCnt_q;
    logic [8:0] txShift_q;
    logic txAllowed;
    logic [1:0] sinSync_q;
    logic [1:0] enASync_q;
    logic [1:0] enBSync_q;

    // routing with fallback when the named channel is not in this mode
    function automatic logic routeChan(input logic bitVal, input logic enA,
        input logic enB);
        if (bitVal == `FS_CHAN_FIRST) begin
            routeChan = enA ? `FS_CHAN_FIRST : `FS_CHAN_SECOND;
        end else begin
            routeChan = enB ? `FS_CHAN_SECOND : `FS_CHAN_FIRST;
        end
    endfunction

    // the link clock runs apart from clk and stalls while the host has a byte unread, so the request, byte and ack crossings are held stable
    // by the clk side until the link side has seen them; chanEnA and chanEnB are synced here straight from the inputs
    always_ff @(posedge link.linkClock or posedge reset) begin
        if (reset) begin
            txReqSync_q <= 2'h0;
            rxAckSync_q <= 2'h0;
            linkEnSync_q <= 2'h0;
            sinSync_q <= 2'h3;
            enASync_q <= 2'h0;
            enBSync_q <= 2'h0;
        end else begin
            txReqSync_q <= {txReqSync_q[0], txReq_q};
            enASync_q <= {enASync_q[0], chanEnA};
            enBSync_q <= {enBSync_q[0], chanEnB};
            rxAckSync_q <= {rxAckSync_q[0], rxAck_q};
            linkEnSync_q <= {linkEnSync_q[0], enSync_q[1]};
            sinSync_q <= {sinSync_q[0], link.serialInLine};
        end
    end

    assign txAllowed = txReqSync_q[1] != txAck_q && linkEnSync_q[1];

    always_ff @(posedge link.linkClock or posedge reset) begin
        if (reset) begin
            state_q <= fast_serial_pkg::LINK_IDLE;
            bitCnt_q <= 4'h0;
            txShift_q <= 9'h1ff;
            link.serialOutLine <= 1'b1;
            link.clearToSendOut <= 1'b0;
            txAck_q <= 1'b0;
            rxTgl_q <= 1'b0;
            rxShift_q <= 8'h00;
            rxChanL_q <= 1'b0;
            rxAckSeen_q <= 1'b0;
            rxPending_q <= 1'b0;
        end else begin
            if (rxAckSync_q[1] != rxAckSeen_q) begin
                rxAckSeen_q <= rxAckSync_q[1];
                rxPending_q <= 1'b0;
            end
            unique case (state_q)
                fast_serial_pkg::LINK_IDLE: begin
                    link.serialOutLine <= 1'b1;
                    link.clearToSendOut <= linkEnSync_q[1] && !rxPending_q;
                    if (link.clearToSendOut && sinSync_q[1] == `FS_START_LEVEL) begin
                        state_q <= fast_serial_pkg::LINK_RX;
                        link.clearToSendOut <= 1'b0;
                        bitCnt_q <= 4'h1;
                    end else if (txAllowed) begin
                        link.serialOutLine <= `FS_START_LEVEL;
                        link.clearToSendOut <= 1'b0;
                        txShift_q <= {routeChan(txChan_q, 1'b1, 1'b1), txByte_q};
                        bitCnt_q <= 4'h1;
                        state_q <= fast_serial_pkg::LINK_TX;
                    end
                end
                fast_serial_pkg::LINK_RX: begin
                    link.clearToSendOut <= 1'b0;
                    bitCnt_q <= bitCnt_q + 4'h1;
                    if (bitCnt_q < `FS_DATA_BITS + 4'h1) begin
                        rxShift_q <= {sinSync_q[1], rxShift_q[7:1]};
                    end else begin
                        rxChanL_q <= routeChan(sinSync_q[1], enASync_q[1], enBSync_q[1]);
                        rxTgl_q <= ~rxTgl_q;
                        rxPending_q <= 1'b1;
                        bitCnt_q <= 4'h0;
                        state_q <= fast_serial_pkg::LINK_IDLE;
                    end
                end
                fast_serial_pkg::LINK_TX: begin
                    // input lags two link clocks, so a start sent while cts was still
                    // high shows up here; back off and retry the byte later
                    if (bitCnt_q <= 4'h2 && sinSync_q[1] == `FS_START_LEVEL) begin
                        link.serialOutLine <= 1'b1;
                        bitCnt_q <= 4'h1;
                        state_q <= fast_serial_pkg::LINK_RX;
                    end else begin
                        link.serialOutLine <= txShift_q[0];
                        txShift_q <= {1'b1, txShift_q[8:1]};
                        bitCnt_q <= bitCnt_q + 4'h1;
                        if (bitCnt_q == `FS_FRAME_BITS - 4'h1) begin
                            txAck_q <= ~txAck_q;
                            bitCnt_q <= 4'h0;
                            state_q <= fast_serial_pkg::LINK_IDLE;
                        end
                    end
                end
                default: begin
                    state_q <= fast_serial_pkg::LINK_IDLE;
                end
            endcase
        end
    end
endmodule

/* src/fast_serial_host.sv */
// external end of the fast serial link; makes the link clock by division
`timescale 1ns/1ps
`include "fast_serial_map.svh"
module fast_serial_host (
    input wire logic clk,
    input wire logic reset,
    fast_serial_if.host link,
    input wire logic [7:0] sendByte,
    input wire logic sendChan,
    input wire logic sendValid,
    output logic sendReady,
    output logic [7:0] recvByte,
    output logic recvChan,
    output logic recvValid,
    input wire logic recvReady
);
    logic [3:0] divCnt_q;
    logic [1:0] ctsSync_q;
    logic [1:0] sdoSync_q;
    logic [3:0] bitCnt_q;
    logic [9:0] shift_q;
    logic [8:0] rxShift_q;
    logic sending_q;
    logic receiving_q;
    logic fall;
    logic rise;

    // ----------------------------------------------------------------
    // clock divider: link clock runs from clk, held low while a received byte is unread
    // ----------------------------------------------------------------
    assign rise = divCnt_q == `FS_CLK_DIV - 4'h1 && !link.linkClock;
    assign fall = divCnt_q == `FS_CLK_DIV - 4'h1 && link.linkClock;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            divCnt_q <= 4'h0;
            link.linkClock <= 1'b0;
        end else if (divCnt_q == `FS_CLK_DIV - 4'h1) begin
            divCnt_q <= 4'h0;
            // stall clock while a received byte is unread
            if (link.linkClock || !recvValid) begin
                link.linkClock <= ~link.linkClock;
            end
        end else begin
            divCnt_q <= divCnt_q + 4'h1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctsSync_q <= 2'h0;
            sdoSync_q <= 2'h3;
        end else begin
            ctsSync_q <= {ctsSync_q[0], link.clearToSendOut};
            sdoSync_q <= {sdoSync_q[0], link.serialOutLine};
        end
    end

    // ----------------------------------------------------------------
    // framing; changes on the falling edge, sampled on rising
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            link.serialInLine <= 1'b1;
            shift_q <= 10'h3ff;
            rxShift_q <= 9'h000;
            bitCnt_q <= 4'h0;
            sending_q <= 1'b0;
            receiving_q <= 1'b0;
            sendReady <= 1'b0;
            recvByte <= 8'h00;
            recvChan <= 1'b0;
            recvValid <= 1'b0;
        end else begin
            sendReady <= !sending_q && !receiving_q && !(sendValid && sendReady);
            if (recvValid && recvReady) begin
                recvValid <= 1'b0;
            end
            if (sendValid && sendReady) begin
                shift_q <= {sendChan, sendByte, `FS_START_LEVEL};
                sending_q <= 1'b1;
            end
            if (fall && sending_q && !receiving_q && bitCnt_q == 4'h0) begin
                if (ctsSync_q[1]) begin
                    link.serialInLine <= shift_q[0];
                    shift_q <= {1'b1, shift_q[9:1]};
                    bitCnt_q <= 4'h1;
                end
            end else if (fall && sending_q && !receiving_q && bitCnt_q != 4'h0) begin
                link.serialInLine <= shift_q[0];
                shift_q <= {1'b1, shift_q[9:1]};
                if (bitCnt_q == `FS_FRAME_BITS) begin
                    link.serialInLine <= 1'b1;
                    sending_q <= 1'b0;
                    bitCnt_q <= 4'h0;
                end else begin
                    bitCnt_q <= bitCnt_q + 4'h1;
                end
            end
            // a byte waiting for cts must not blind us to an incoming frame
            if (rise && !(sending_q && !receiving_q && bitCnt_q != 4'h0)) begin
                if (!receiving_q && sdoSync_q[1] == `FS_START_LEVEL) begin
                    receiving_q <= 1'b1;
                    bitCnt_q <= 4'h1;
                end else if (receiving_q) begin
                    rxShift_q <= {sdoSync_q[1], rxShift_q[8:1]};
                    bitCnt_q <= bitCnt_q + 4'h1;
                    if (bitCnt_q == `FS_FRAME_BITS - 4'h1) begin
                        recvByte <= rxShift_q[8:1];
                        recvChan <= sdoSync_q[1];
                        recvValid <= 1'b1;
                        receiving_q <= 1'b0;
                        bitCnt_q <= 4'h0;
                    end
                end
            end
        end
    end
endmodule

/* verif/fast_serial_monitor.sv */
// assertion checker on the wires joining the two link ends
`timescale 1ns/1ps
module fast_serial_monitor (
    input wire logic clk,
    input wire logic reset,
    input wire logic linkClock,
    input wire logic serialInLine,
    input wire logic serialOutLine,
    input wire logic clearToSendOut
);
    // ----------------------------------------
    // incoming frame position
    // ----------------------------------------
    // 1 to 9 count the bits after the start bit
    logic [3:0] rxCnt_q;
    always_ff @(posedge linkClock or posedge reset) begin
        if (reset)
            rxCnt_q <= 4'h0;
        else if (rxCnt_q == 4'h9)
            rxCnt_q <= 4'h0;
        else if (rxCnt_q != 4'h0 || !serialInLine)
            rxCnt_q <= rxCnt_q + 4'h1;
    end
    // ----------------------------------------
    // link checks
    // ----------------------------------------
    a_cts_falls_fast: assert property (@(posedge linkClock) disable iff (reset)
        rxCnt_q == 4'h0 && !serialInLine && clearToSendOut |-> ##[1:4] !clearToSendOut)
        else $error("cts late after start");
    a_cts_low_frame: assert property (@(posedge linkClock) disable iff (reset)
        rxCnt_q >= 4'h4 |-> !clearToSendOut)
        else $error("cts high in frame");
    a_cts_hold_low: assert property (@(posedge linkClock) disable iff (reset)
        $fell(clearToSendOut) && rxCnt_q != 4'h0 |-> !clearToSendOut [*5])
        else $error("cts rose too early");
    a_send_needs_cts: assert property (@(posedge linkClock) disable iff (reset)
        rxCnt_q == 4'h0 && !serialInLine |-> clearToSendOut)
        else $error("start without cts");
    a_rx_idle_after: assert property (@(posedge linkClock) disable iff (reset)
        rxCnt_q == 4'h9 |=> serialInLine)
        else $error("input frame too long");
    a_half_duplex: assert property (@(posedge linkClock) disable iff (reset)
        rxCnt_q >= 4'h4 |-> serialOutLine)
        else $error("output busy in rx");
    a_reset_outputs: assert property (@(posedge clk) disable iff (reset)
        $fell(reset) |-> serialOutLine && !clearToSendOut)
        else $error("bad levels at reset");
    a_clock_high_time: assert property (@(posedge clk) disable iff (reset)
        $rose(linkClock) |-> linkClock [*4])
        else $error("link clock high short");
    c_tx: cover property (@(posedge linkClock) $fell(serialOutLine));
    c_rx: cover property (@(posedge linkClock) rxCnt_q == 4'h9);
    c_both: cover property (@(posedge linkClock) rxCnt_q == 4'h0 && !serialInLine
        && !serialOutLine);
endmodule

/* verif/opto_isolated_fast_serial_link_tb.sv */
// bench joining the device and host ends of the fast serial link
`timescale 1ns/1ps
`include "fast_serial_map.svh"
module opto_isolated_fast_serial_link_tb;
    logic clk, reset, chanEnA, chanEnB, modeCmdValid, txChan, txValid, txReady;
    logic rxChan, rxValid, rxReady, sendChan, sendValid, sendReady, recvChan, recvValid;
    logic recvReady;
    logic [1:0] modeCmd;
    logic [3:0] hs;
    logic [7:0] txByte, rxByte, sendByte, recvByte;
    int errCount = 0;
    int checksDone = 0;
    assign hs = {recvValid, rxValid, txReady, sendReady};
    fast_serial_if link();
    fast_serial_device fast_serial_device_i (.clk(clk), .reset(reset), .link(link),
        .chanEnA(chanEnA), .chanEnB(chanEnB), .modeCmd(modeCmd), .modeCmdValid(modeCmdValid),
        .txByte(txByte), .txChan(txChan), .txValid(txValid), .txReady(txReady),
        .rxByte(rxByte), .rxChan(rxChan), .rxValid(rxValid), .rxReady(rxReady));
    fast_serial_host fast_serial_host_i (.clk(clk), .reset(reset), .link(link),
        .sendByte(sendByte), .sendChan(sendChan), .sendValid(sendValid), .sendReady(sendReady),
        .recvByte(recvByte), .recvChan(recvChan), .recvValid(recvValid), .recvReady(recvReady));
    fast_serial_monitor fast_serial_monitor_i (.clk(clk), .reset(reset),
        .linkClock(link.linkClock), .serialInLine(link.serialInLine),
        .serialOutLine(link.serialOutLine), .clearToSendOut(link.clearToSendOut));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
        checksDone++;
        if (got !== exp) begin
            errCount++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // bounded so a stuck handshake shows as a mismatch, not a hang
    task automatic waitSig(input int idx);
        for (int n = 0; n < 4000; n++) begin
            if (hs[idx] === 1'b1)
                return;
            @(negedge clk);
        end
        check("handshake", 10'h1, 10'h0);
    endtask
    task automatic hostSend(input logic [7:0] b, input logic c);
        @(negedge clk);
        {sendChan, sendByte} = {c, b};
        sendValid = 1'b1;
        waitSig(0);
        @(negedge clk);
        sendValid = 1'b0;
    endtask
    task automatic devSend(input logic [7:0] b, input logic c);
        @(negedge clk);
        {txChan, txByte} = {c, b};
        txValid = 1'b1;
        waitSig(1);
        @(negedge clk);
        txValid = 1'b0;
    endtask
    task automatic takeRx(input logic [7:0] b, input logic c);
        @(negedge clk);
        waitSig(2);
        check("device rx", {1'b0, c, b}, {1'b0, rxChan, rxByte});
        rxReady = 1'b1;
        @(negedge clk);
        rxReady = 1'b0;
    endtask
    task automatic takeRecv(input logic [7:0] b, input logic c);
        @(negedge clk);
        waitSig(3);
        check("host rx", {1'b0, c, b}, {1'b0, recvChan, recvByte});
        recvReady = 1'b1;
        @(negedge clk);
        recvReady = 1'b0;
    endtask
    task automatic pulseMode(input logic [1:0] m);
        @(negedge clk);
        modeCmd = m;
        modeCmdValid = 1'b1;
        @(negedge clk);
        modeCmdValid = 1'b0;
        repeat (100) @(negedge clk);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic testRouting;
        logic [1:0] en;
        logic [7:0] b;
        for (int i = 0; i < 6; i++) begin
            en = (i < 2) ? 2'h1 : (i < 4) ? 2'h2 : 2'h3;
            b = {5'h10, i[2:0]};
            {chanEnB, chanEnA} = en;
            repeat (200) @(negedge clk);
            hostSend(b, i[0]);
            takeRx(b, en[i[0]] ? i[0] : ~i[0]);
        end
        $display("routing test done");
    endtask
    task automatic testSend;
        logic [9:0] bits;
        fork
            devSend(8'h2d, 1'b1);
            begin
                @(negedge link.serialOutLine);
                for (int k = 0; k < 10; k++) begin
                    @(negedge link.linkClock);
                    bits[k] = link.serialOutLine;
                end
            end
        join
        check("wire frame", {1'b1, 8'h2d, 1'b0}, bits);
        devSend(8'hb4, 1'b0);
        takeRecv(8'h2d, 1'b1);
        takeRecv(8'hb4, 1'b0);
        $display("send test done");
    endtask
    task automatic testHold;
        pulseMode(`FS_HOLD_CMD);
        devSend(8'h5a, 1'b0);
        repeat (600) @(negedge clk);
        check("held link", 10'h1, {8'h0, recvValid, link.serialOutLine});
        pulseMode(`FS_RELEASE_CMD);
        takeRecv(8'h5a, 1'b0);
        $display("hold test done");
    endtask
    task automatic testClash;
        fork
            devSend(8'hc3, 1'b0);
            hostSend(8'h3c, 1'b1);
        join
        fork
            takeRx(8'h3c, 1'b1);
            takeRecv(8'hc3, 1'b0);
        join
        $display("contention test done");
    endtask
    task automatic testDisabled;
        {chanEnB, chanEnA} = 2'h0;
        repeat (200) @(negedge clk);
        fork
            hostSend(8'h99, 1'b0);
        join_none
        repeat (800) @(negedge clk);
        check("disabled", 10'h0, {8'h0, rxValid, link.clearToSendOut});
        chanEnA = 1'b1;
        takeRx(8'h99, 1'b0);
        $display("disable test done");
    endtask
    task automatic finalReport;
        $display("checks %0d mismatches %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        reset = 1'b1;
        {chanEnB, chanEnA, modeCmd} = 4'hc;
        {modeCmdValid, txChan, txValid, rxReady, sendChan, sendValid, recvReady} = 7'h0;
        {txByte, sendByte} = 16'h0;
        repeat (8) @(negedge clk);
        reset = 1'b0;
        repeat (4) @(negedge clk);
        check("reset out", 10'h1, {7'h0, rxValid, recvValid, link.serialOutLine});
        testRouting;
        testSend;
        testHold;
        testClash;
        testDisabled;
        finalReport;
    end
    // tests need about 5000 cycles
    initial begin
        repeat (60000) @(posedge clk);
        errCount++;
        $display("wrong value watchdog expected done seen hang");
        finalReport;
    end
endmodule
